// file: verilog/cws_pkg.sv
package cws_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LAUNCH_CTRL_OFS = 8'h6F;
  localparam logic [7:0] PROGRESS_STAT_OFS = 8'h70;
  localparam logic [15:0] LAUNCH_CTRL_RST = 16'h0000;
  localparam logic [15:0] PROGRESS_STAT_RST = 16'h0000;
  localparam int ABORT_BIT = 9;
  localparam int LAUNCH_BIT = 8;
  localparam int PTR_LSB = 0;
  localparam int CUR_LSB = 4;
  localparam int ACTIVE_BIT = 0;

  // ----------------------------------------------------------------
  // Step table layout
  // ----------------------------------------------------------------
  localparam int PTR_W = 6;
  localparam int RAM_DEPTH = 32;
  localparam logic [5:0] RAM_LAST = 6'h1F;
  localparam logic [5:0] ROM_LAST = 6'h30;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned STEP_UNIT_NS = 62500;
  localparam int unsigned STEP_BASE_UNITS = 8;

  typedef struct packed {
    logic final_step_marker;
    logic [3:0] post_step_wait_code;
    logic [2:0] step_field_width;
    logic [3:0] step_field_lsb_position;
    logic [7:0] step_target_register;
    logic [7:0] step_field_value;
  } cws_step_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] mask;
    logic [15:0] data;
  } cws_ctl_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_WAIT = 2'b11
  } cws_state_t;

endpackage

// file: verilog/cws_step_table.sv
`timescale 1ns/10ps
module cws_step_table (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Load port for the writable part
  input wire logic load_en,
  input wire logic [4:0] load_idx,
  input wire cws_pkg::cws_step_t load_step,
  // Read port, one cycle latency
  input wire logic rd_en,
  input wire logic [5:0] rd_idx,
  output cws_pkg::cws_step_t rd_step
);
  import cws_pkg::*;

  cws_step_t ram_mem [RAM_DEPTH];

  // ----------------------------------------------------------------
  // Fixed steps: each clears bit 0 of its own index as register; the
  // last one ends the sequence.
  // ----------------------------------------------------------------
  function automatic cws_step_t rom_step(input logic [5:0] idx);
    cws_step_t s;
    s = '0;
    s.step_target_register = {2'b00, idx};
    s.final_step_marker = (idx == ROM_LAST);
    return s;
  endfunction

  always_ff @(posedge clk) begin
    if (ce && load_en) begin
      ram_mem[load_idx] <= load_step;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && rd_en) begin
      if (rd_idx <= RAM_LAST) begin
        rd_step <= ram_mem[rd_idx[4:0]];
      end else begin
        rd_step <= rom_step(rd_idx);
      end
    end
  end

endmodule // cws_step_table

// file: verilog/cws_sequencer.sv
// What this block does
// - Writing one to abort stops the run and returns access to the host.
// - Writing one to launch starts execution at the launch step pointer.
// - Steps execute consecutively until a step with the final marker runs.
// - On completion the sequencer clears the launch trigger bit itself.
// - Pointer values 0 to 31 address writable RAM steps.
// - Values 32 to 48 address ROM steps; 49 to 63 are reserved.
// - A read-only field shows the most recently accessed step location.
// - A read-only flag reads one while running, zero when idle.
// - While active, host control writes are refused; host waits for idle.
// - Step duration is 62.5 us times two to the wait code plus eight.
// - Each step writes a 1 to 8 bit field at its start position.
// - The sequencer halts after executing a step with the final marker.
`timescale 1ns/10ps
module cws_sequencer #(
  parameter int unsigned STEP_UNIT_NS_P = cws_pkg::STEP_UNIT_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Host control-register port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // Step table load port
  input wire logic load_en,
  input wire logic [4:0] load_idx,
  input wire cws_pkg::cws_step_t load_step,
  // Write port into the device control registers
  output cws_pkg::cws_ctl_wr_t ctl_wr,
  // Status
  output logic sequencer_active_flag
);
  import cws_pkg::*;

  cws_state_t state_reg;
  cws_state_t state_next;
  logic sequence_launch_trigger;
  logic [5:0] launch_step_pointer;
  logic [5:0] active_step_pointer;
  logic [31:0] elapsed_ns_reg;
  logic [31:0] target_ns;
  cws_step_t step;
  logic ctrl_wr;
  logic launch_req;
  logic abort_req;
  logic wait_done;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] field_mask(input logic [2:0] w, input logic [3:0] lsb);
    logic [15:0] m;
    m = 16'(({1'b0, 8'hFF} >> (3'd7 - w)) & 9'h0FF);
    return m << lsb;
  endfunction

  function automatic logic [31:0] step_time_ns(input logic [3:0] code);
    logic [31:0] units;
    units = (32'h1 << code) + 32'(STEP_BASE_UNITS);
    return units * 32'(STEP_UNIT_NS_P);
  endfunction

  assign ctrl_wr = host_wr && (host_addr == LAUNCH_CTRL_OFS);
  assign launch_req = ctrl_wr && host_wdata[LAUNCH_BIT] && !host_wdata[ABORT_BIT];
  assign abort_req = ctrl_wr && host_wdata[ABORT_BIT];
  assign target_ns = step_time_ns(step.post_step_wait_code);
  assign wait_done = (elapsed_ns_reg + 32'(CLK_PERIOD_NS)) >= target_ns;

  cws_step_table u_table (
    .clk(clk),
    .ce(ce),
    .load_en(load_en),
    .load_idx(load_idx),
    .load_step(load_step),
    .rd_en(state_reg == ST_FETCH),
    .rd_idx(active_step_pointer),
    .rd_step(step)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (launch_req) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (active_step_pointer > ROM_LAST) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (wait_done) begin
          state_next = step.final_step_marker ? ST_IDLE : ST_FETCH;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (abort_req) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      active_step_pointer <= PROGRESS_STAT_RST[CUR_LSB +: PTR_W];
    end else if (ce) begin
      if (state_reg == ST_IDLE && launch_req) begin
        active_step_pointer <= host_wdata[PTR_LSB +: PTR_W];
      end else if (state_reg == ST_WAIT && wait_done && !step.final_step_marker) begin
        active_step_pointer <= active_step_pointer + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      elapsed_ns_reg <= '0;
    end else if (ce) begin
      if (state_reg == ST_IDLE || state_next == ST_FETCH) begin
        elapsed_ns_reg <= '0;
      end else begin
        elapsed_ns_reg <= elapsed_ns_reg + 32'(CLK_PERIOD_NS);
      end
    end
  end

  // ----------------------------------------------------------------
  // Launch control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      launch_step_pointer <= LAUNCH_CTRL_RST[PTR_LSB +: PTR_W];
      sequence_launch_trigger <= LAUNCH_CTRL_RST[LAUNCH_BIT];
    end else if (ce) begin
      if (abort_req) begin
        sequence_launch_trigger <= 1'b0;
      end else if (state_reg == ST_IDLE && ctrl_wr) begin
        launch_step_pointer <= host_wdata[PTR_LSB +: PTR_W];
        sequence_launch_trigger <= host_wdata[LAUNCH_BIT];
      end else if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
        sequence_launch_trigger <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sequencer_active_flag <= PROGRESS_STAT_RST[ACTIVE_BIT];
    end else if (ce) begin
      sequencer_active_flag <= (state_next != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Control register write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl_wr <= '0;
    end else if (ce) begin
      ctl_wr.wr <= 1'b0;
      if (state_reg == ST_EXEC && !abort_req) begin
        ctl_wr.wr <= 1'b1;
        ctl_wr.addr <= step.step_target_register;
        ctl_wr.mask <= field_mask(step.step_field_width, step.step_field_lsb_position);
        ctl_wr.data <= (16'(step.step_field_value) << step.step_field_lsb_position)
                       & field_mask(step.step_field_width, step.step_field_lsb_position);
      end else if (host_wr && state_reg == ST_IDLE && host_addr != LAUNCH_CTRL_OFS
                   && host_addr != PROGRESS_STAT_OFS) begin
        ctl_wr.wr <= 1'b1;
        ctl_wr.addr <= host_addr;
        ctl_wr.mask <= 16'hFFFF;
        ctl_wr.data <= host_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      host_rdata <= 16'h0000;
    end else if (ce && host_rd) begin
      host_rdata <= 16'h0000;
      if (host_addr == LAUNCH_CTRL_OFS) begin
        host_rdata[LAUNCH_BIT] <= sequence_launch_trigger;
        host_rdata[PTR_LSB +: PTR_W] <= launch_step_pointer;
      end else if (host_addr == PROGRESS_STAT_OFS) begin
        host_rdata[CUR_LSB +: PTR_W] <= active_step_pointer;
        host_rdata[ACTIVE_BIT] <= sequencer_active_flag;
      end
    end
  end

endmodule // cws_sequencer

// file: testbench/cws_ctl_reg_model.sv
`timescale 1ns/10ps
module cws_ctl_reg_model (
  // Clock
  clk,
  // Control-register write port
  ctl_wr
);
  import cws_pkg::*;
  input wire logic clk;
  input wire cws_ctl_wr_t ctl_wr;
  // ----------------------------------------------------------------
  // Control registers that receive the sequencer writes
  // ----------------------------------------------------------------
  logic [15:0] regs [256];
  initial begin
    foreach (regs[i]) begin
      regs[i] = 16'h0000;
    end
  end
  always @(posedge clk) begin
    if (ctl_wr.wr === 1'h1) begin
      regs[ctl_wr.addr] <= (regs[ctl_wr.addr] & ~ctl_wr.mask) | ctl_wr.data;
    end
  end
endmodule // cws_ctl_reg_model

// file: testbench/cws_sequencer_sva.sv
`timescale 1ns/10ps
module cws_sequencer_chk #(
  parameter int unsigned STEP_UNIT_NS_P = 62500
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Host port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  // Outputs
  input wire cws_pkg::cws_ctl_wr_t ctl_wr,
  input wire logic sequencer_active_flag
);
  import cws_pkg::*;
  logic act;
  assign act = sequencer_active_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_lc;
    ce && host_wr && host_addr == LAUNCH_CTRL_OFS;
  endsequence
  sequence s_launch;
    s_wr_lc ##0 !act && host_wdata[9:8] == 2'h1 && host_wdata[5:0] <= ROM_LAST;
  endsequence
  sequence s_step_wr;
    ctl_wr.wr && ctl_wr.mask != 16'hFFFF;
  endsequence
  property p_launch;
    s_launch |=> act ##2 ctl_wr.wr;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not start a step");
  property p_abort;
    s_wr_lc ##0 host_wdata[9] |=> !act && !ctl_wr.wr;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop the run");
  property p_forward;
    ce && host_wr && !act && host_addr != LAUNCH_CTRL_OFS && host_addr != PROGRESS_STAT_OFS
      |=> ctl_wr.wr && ctl_wr.mask == 16'hFFFF && ctl_wr.data == $past(host_wdata);
  endproperty
  a_forward: assert property (p_forward) else $error("idle host write not forwarded");
  property p_refuse;
    ce && host_wr && act |=> !(ctl_wr.wr && ctl_wr.mask == 16'hFFFF);
  endproperty
  a_refuse: assert property (p_refuse) else $error("host write passed while active");
  property p_field;
    s_step_wr |-> (ctl_wr.data & ~ctl_wr.mask) == 16'h0000 && $countones(ctl_wr.mask) <= 8;
  endproperty
  a_field: assert property (p_field) else $error("step write field malformed");
  property p_step_act;
    s_step_wr |-> act;
  endproperty
  a_step_act: assert property (p_step_act) else $error("step write while idle");
  property p_rd_stat;
    ce && host_rd && host_addr == PROGRESS_STAT_OFS
      |=> host_rdata[0] == $past(act) && host_rdata[3:1] == 3'h0;
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status read wrong");
  property p_rd_ctl;
    ce && host_rd && host_addr == LAUNCH_CTRL_OFS |=> host_rdata[15:9] == 7'h00;
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("abort bit read back");
endmodule // cws_sequencer_chk
bind cws_sequencer cws_sequencer_chk #(.STEP_UNIT_NS_P(STEP_UNIT_NS_P)) u_chk (.clk(clk),
  .nrst(nrst), .ce(ce), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_rdata(host_rdata), .ctl_wr(ctl_wr),
  .sequencer_active_flag(sequencer_active_flag));

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import cws_pkg::*;
  localparam int UNIT = 400;
  logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, host_wr = 1'h0, host_rd = 1'h0, load_en = 1'h0;
  logic [7:0] host_addr = 8'h00, a;
  logic [15:0] host_wdata = 16'h0000, host_rdata, d, v, o;
  logic [4:0] load_idx = 5'h00;
  cws_step_t load_step = '0;
  cws_step_t st [4];
  cws_ctl_wr_t ctl_wr;
  logic act;
  int err_total = 0, n_tests = 0, seed = 473, cyc = 0, n, exp_n = 0;
  always #20 clk = ~clk;
  cws_sequencer #(.STEP_UNIT_NS_P(UNIT)) dut (.clk(clk), .nrst(nrst), .ce(ce),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .load_en(load_en), .load_idx(load_idx), .load_step(load_step),
    .ctl_wr(ctl_wr), .sequencer_active_flag(act));
  cws_ctl_reg_model m (.clk(clk), .ctl_wr(ctl_wr));
  // ----------------------------------------------------------------
  // Host cycles and checks
  // ----------------------------------------------------------------
  function automatic logic [15:0] fld(input cws_step_t s);
    logic [15:0] k;
    k = ((16'h1 << (4'(s.step_field_width) + 4'h1)) - 16'h1) << s.step_field_lsb_position;
    return ({8'h00, s.step_field_value} << s.step_field_lsb_position) & k;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
    @(posedge clk);
    host_wr <= 1'h1;
    host_addr <= ad;
    host_wdata <= dt;
    @(posedge clk);
    host_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [15:0] dt);
    @(posedge clk);
    host_rd <= 1'h1;
    host_addr <= ad;
    @(posedge clk);
    host_rd <= 1'h0;
    #1;
    dt = host_rdata;
  endtask
  task automatic wait_idle();
    n = 0;
    #1;
    while (act === 1'h1 && n < 50000) begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    rd(LAUNCH_CTRL_OFS, d);
    chk("launch_ctrl", LAUNCH_CTRL_RST, d);
    rd(PROGRESS_STAT_OFS, d);
    chk("progress", PROGRESS_STAT_RST, d);
    for (int i = 0; i < 6; i++) begin
      a = 8'($random(seed)) & 8'h3F;
      v = 16'($random(seed));
      wr(a, v);
      @(posedge clk);
      #1 chk("forwarded", v, m.regs[a]);
    end
    for (int i = 0; i < 4; i++) begin
      st[i] = 28'($random(seed));
      st[i].final_step_marker = 1'(i == 3);
      st[i].post_step_wait_code = 4'($random(seed) & 1);
      st[i].step_target_register = 8'h80 + 8'(i);
      exp_n += UNIT * ((1 << st[i].post_step_wait_code) + 8) / 40;
      @(posedge clk);
      load_en <= 1'h1;
      load_idx <= 5'(i);
      load_step <= st[i];
      @(posedge clk);
      load_en <= 1'h0;
    end
    wr(LAUNCH_CTRL_OFS, 16'h0100);
    wait_idle();
    chk("run_length", 16'(exp_n), 16'(n));
    for (int i = 0; i < 4; i++) chk("step_field", fld(st[i]), m.regs[8'h80 + i]);
    rd(LAUNCH_CTRL_OFS, d);
    chk("launch_clear", 16'h0000, d);
    rd(PROGRESS_STAT_OFS, d);
    chk("current_index", 16'h0030, d);
    v = ~fld(st[1]);
    wr(8'h81, v);
    wr(LAUNCH_CTRL_OFS, 16'h0100);
    o = m.regs[a];
    wr(a, ~o);
    wr(LAUNCH_CTRL_OFS, 16'h0200);
    #1 chk("abort_flag", 16'h0000, {15'h0, act});
    repeat (300) @(posedge clk);
    #1 chk("abort_stop", v, m.regs[8'h81]);
    chk("blocked", o, m.regs[a]);
    rd(LAUNCH_CTRL_OFS, d);
    chk("abort_launch", 16'h0000, d);
    wr(8'h2F, 16'hFFFF);
    wr(8'h30, 16'hFFFF);
    wr(LAUNCH_CTRL_OFS, 16'h012F);
    // Freeze the run for 20 edges; the two ROM steps must still take their full time.
    repeat (5) @(posedge clk);
    ce <= 1'h0;
    repeat (20) @(posedge clk);
    ce <= 1'h1;
    wait_idle();
    chk("rom_length", 16'(2 * UNIT * 9 / 40 - 5), 16'(n));
    chk("rom_first", 16'hFFFE, m.regs[8'h2F]);
    chk("rom_last", 16'hFFFE, m.regs[8'h30]);
    rd(PROGRESS_STAT_OFS, d);
    chk("rom_index", 16'h0300, d);
    wr(LAUNCH_CTRL_OFS, 16'h0132);
    wait_idle();
    chk("reserved", 16'h0000, 16'(n > 2));
    finish_test();
  end
endmodule // tb_top
